// File: ssp_tx.sv
`timescale 1ns/1ps
`include "ssp_defs.svh"

module ssp_tx
#(
  parameter int ADDR_W = 8,
  parameter int FIFO_DEPTH = 4
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel 1 sample stream
  input wire logic [31:0] smp_data,
  input wire logic smp_valid,
  output logic smp_ready,
  // Serial link
  input wire logic bclk_pin,
  input wire logic fsync_pin,
  output ssp_pkg::ssp_pin_s first_serial_out_pin,
  output ssp_pkg::ssp_pin_s second_serial_out_pin
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] format_r;
  logic [7:0] txctl_r;
  logic [4:0] tx_msb_delay_cycles_r;
  logic [7:0] pin_sel_r;
  ssp_pkg::ssp_ch1_s ch1_r;
  logic underrun_r;
  logic right_half_r;

  ssp_pkg::ssp_framing_e framing_select;
  logic [1:0] slot_bit_length;
  logic idle_cycle_drive;
  logic chan1_pin_choice;

  assign framing_select = ssp_pkg::ssp_framing_e'(format_r[`SSP_FMT_LSB+:2]);
  assign slot_bit_length = format_r[`SSP_WLEN_LSB+:2];
  assign idle_cycle_drive = txctl_r[`SSP_FILL_BIT];
  assign chan1_pin_choice = pin_sel_r[0];

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    reg_hit = (idx == `SSP_IDX_FORMAT) || (idx == `SSP_IDX_TXCTL) || (idx == `SSP_IDX_OFFSET) ||
              (idx == `SSP_IDX_PINSEL) || (idx == `SSP_IDX_CH1) || (idx == `SSP_IDX_STATUS);
  endfunction

  function automatic logic [5:0] word_len(input logic [1:0] code);
    unique case (code)
      2'b00: word_len = `SSP_LEN16;
      2'b01: word_len = `SSP_LEN20;
      2'b10: word_len = `SSP_LEN24;
      2'b11: word_len = `SSP_LEN32;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic wr_go;
  logic wr_take;
  logic rd_go;
  logic rd_take;
  logic [5:0] wr_idx;
  logic underrun_clr;
  logic fifo_empty;
  logic fifo_full;

  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  assign wr_take = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
  assign rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  assign rd_take = s_axi_arready & s_axi_arvalid;
  assign wr_idx = s_axi_awaddr[7:2];
  assign underrun_clr = wr_take & s_axi_wstrb[0] & (wr_idx == `SSP_IDX_STATUS) &
                        s_axi_wdata[`SSP_ST_UNDERRUN];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSP_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      if (wr_take)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_hit(s_axi_awaddr) ? `SSP_RESP_OKAY : `SSP_RESP_DECERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SSP_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= rd_go;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= reg_hit(s_axi_araddr) ? `SSP_RESP_OKAY : `SSP_RESP_DECERR;
        unique case (s_axi_araddr[7:2])
          `SSP_IDX_FORMAT: s_axi_rdata <= {24'h0, format_r};
          `SSP_IDX_TXCTL: s_axi_rdata <= {24'h0, txctl_r};
          `SSP_IDX_OFFSET: s_axi_rdata <= {27'h0, tx_msb_delay_cycles_r};
          `SSP_IDX_PINSEL: s_axi_rdata <= {24'h0, pin_sel_r};
          `SSP_IDX_CH1: s_axi_rdata <= {26'h0, ch1_r};
          `SSP_IDX_STATUS: s_axi_rdata <= {28'h0, right_half_r, fifo_full, fifo_empty, underrun_r};
          default: s_axi_rdata <= 32'h0;
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      format_r <= `SSP_RST_FORMAT;
      txctl_r <= `SSP_RST_TXCTL;
      tx_msb_delay_cycles_r <= 5'(`SSP_RST_OFFSET);
      pin_sel_r <= `SSP_RST_PINSEL;
      ch1_r <= 6'(`SSP_RST_CH1);
    end
    else if (wr_take && s_axi_wstrb[0])
    begin
      unique case (wr_idx)
        `SSP_IDX_FORMAT: format_r <= s_axi_wdata[7:0];
        `SSP_IDX_TXCTL: txctl_r <= s_axi_wdata[7:0];
        `SSP_IDX_OFFSET: tx_msb_delay_cycles_r <= s_axi_wdata[`SSP_OFS_MSB:0];
        `SSP_IDX_PINSEL: pin_sel_r <= s_axi_wdata[7:0];
        `SSP_IDX_CH1: ch1_r <= s_axi_wdata[`SSP_CH1_ON_BIT:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sample FIFO
  // ----------------------------------------------------------------
  logic fifo_in_ready;
  logic [31:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_take;

  ssp_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(smp_data),
    .in_valid(fifo_take),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  assign fifo_empty = ~fifo_valid;
  assign fifo_full = ~fifo_in_ready;
  assign fifo_take = smp_valid & smp_ready;

  // Ready is registered, so it drops for a cycle after each take; a take then always finds room
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      smp_ready <= 1'b0;
    end
    else
    begin
      smp_ready <= fifo_in_ready & ~fifo_take;
    end
  end

  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  logic [1:0] bclk_sync_r;
  logic [1:0] fsync_sync_r;
  logic bclk_prev_r;
  logic fsync_prev_r;
  logic bclk_rise;
  logic bclk_fall;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bclk_sync_r <= 2'b00;
      fsync_sync_r <= 2'b00;
      bclk_prev_r <= 1'b0;
    end
    else
    begin
      bclk_sync_r <= {bclk_sync_r[0], bclk_pin};
      fsync_sync_r <= {fsync_sync_r[0], fsync_pin};
      bclk_prev_r <= bclk_sync_r[1];
    end
  end

  assign bclk_rise = bclk_sync_r[1] & ~bclk_prev_r;
  assign bclk_fall = ~bclk_sync_r[1] & bclk_prev_r;

  // ----------------------------------------------------------------
  // Frame position and slot match
  // ----------------------------------------------------------------
  logic [10:0] bit_cnt_r;
  logic fs_rise;
  logic fs_fall;
  logic half_start;
  logic half_right;
  logic [10:0] cnt_nxt;
  logic right_nxt;
  logic [5:0] len;
  logic [4:0] slot_in_half;
  logic slot_is_right;
  logic [10:0] slot_start;
  logic slot_load;

  assign fs_rise = fsync_sync_r[1] & ~fsync_prev_r;
  assign fs_fall = ~fsync_sync_r[1] & fsync_prev_r;
  assign len = word_len(slot_bit_length);

  always_comb
  begin
    half_start = 1'b0;
    half_right = 1'b0;
    unique case (framing_select)
      ssp_pkg::SSP_FMT_I2S:
      begin
        half_start = fs_rise | fs_fall;
        half_right = fs_rise;
      end
      ssp_pkg::SSP_FMT_LEFTJ:
      begin
        half_start = fs_rise | fs_fall;
        half_right = fs_fall;
      end
      default:
      begin
        half_start = fs_rise;
        half_right = 1'b0;
      end
    endcase
  end

  assign cnt_nxt = half_start ? 11'h0 : ((bit_cnt_r == `SSP_CNT_MAX) ? bit_cnt_r : bit_cnt_r + 11'h1);
  assign right_nxt = half_start ? half_right : right_half_r;

  always_comb
  begin
    if (framing_select == ssp_pkg::SSP_FMT_I2S || framing_select == ssp_pkg::SSP_FMT_LEFTJ)
    begin
      slot_in_half = {1'b0, ch1_r.chan1_slot_index[3:0]};
      slot_is_right = ch1_r.chan1_slot_index[4];
    end
    else
    begin
      slot_in_half = ch1_r.chan1_slot_index;
      slot_is_right = 1'b0;
    end
  end

  assign slot_start = 11'(tx_msb_delay_cycles_r) + 11'(slot_in_half) * 11'(len);
  assign slot_load = bclk_rise & ch1_r.chan1_output_on & (cnt_nxt == slot_start) &
                     (right_nxt == slot_is_right);
  assign fifo_pop = slot_load;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bit_cnt_r <= `SSP_CNT_MAX;
      right_half_r <= 1'b0;
      fsync_prev_r <= 1'b0;
    end
    else if (bclk_rise)
    begin
      bit_cnt_r <= cnt_nxt;
      right_half_r <= right_nxt;
      fsync_prev_r <= fsync_sync_r[1];
    end
  end

  // Underrun: set wins over a software clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      underrun_r <= 1'b0;
    end
    else if (slot_load && !fifo_valid)
    begin
      underrun_r <= 1'b1;
    end
    else if (underrun_clr)
    begin
      underrun_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Serializer and pin drive
  // ----------------------------------------------------------------
  logic [31:0] shift_r;
  logic [5:0] bits_left_r;
  ssp_pkg::ssp_pin_s idle_pin;
  ssp_pkg::ssp_pin_s data_pin;

  assign idle_pin = '{d: 1'b0, oe: ~idle_cycle_drive};
  assign data_pin = '{d: shift_r[31], oe: 1'b1};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shift_r <= 32'h0;
      bits_left_r <= 6'h0;
    end
    else if (slot_load)
    begin
      shift_r <= fifo_valid ? fifo_data : 32'h0;
      bits_left_r <= len;
    end
    else if (bclk_fall && bits_left_r != 6'h0)
    begin
      shift_r <= {shift_r[30:0], 1'b0};
      bits_left_r <= bits_left_r - 6'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      first_serial_out_pin <= '{d: 1'b0, oe: 1'b0};
      second_serial_out_pin <= '{d: 1'b0, oe: 1'b0};
    end
    else if (bclk_fall)
    begin
      first_serial_out_pin <= idle_pin;
      second_serial_out_pin <= idle_pin;
      if (bits_left_r != 6'h0)
      begin
        if (chan1_pin_choice)
        begin
          second_serial_out_pin <= data_pin;
        end
        else
        begin
          first_serial_out_pin <= data_pin;
        end
      end
    end
  end

endmodule

// File: ssp_defs.svh
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define SSP_IDX_FORMAT 6'h1a
`define SSP_IDX_TXCTL 6'h1b
`define SSP_IDX_OFFSET 6'h1c
`define SSP_IDX_PINSEL 6'h1d
`define SSP_IDX_CH1 6'h1e
`define SSP_IDX_STATUS 6'h30

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SSP_RST_FORMAT 8'h30
`define SSP_RST_TXCTL 8'h00
`define SSP_RST_OFFSET 8'h00
`define SSP_RST_PINSEL 8'h00
`define SSP_RST_CH1 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSP_FMT_LSB 6
`define SSP_WLEN_LSB 4
`define SSP_FILL_BIT 6
`define SSP_OFS_MSB 4
`define SSP_CH1_ON_BIT 5
`define SSP_SLOT_MSB 4
`define SSP_ST_UNDERRUN 0
`define SSP_ST_EMPTY 1
`define SSP_ST_FULL 2
`define SSP_ST_RIGHT 3

// ----------------------------------------------------------------
// Word lengths and responses
// ----------------------------------------------------------------
`define SSP_LEN16 6'd16
`define SSP_LEN20 6'd20
`define SSP_LEN24 6'd24
`define SSP_LEN32 6'd32
`define SSP_RESP_OKAY 2'b00
`define SSP_RESP_DECERR 2'b11
`define SSP_CNT_MAX 11'h7ff

`endif

// File: ssp_pkg.sv
package ssp_pkg;

  typedef enum logic [1:0]
  {
    SSP_FMT_TDM = 2'b00,
    SSP_FMT_I2S = 2'b01,
    SSP_FMT_LEFTJ = 2'b10,
    SSP_FMT_RSVD = 2'b11
  } ssp_framing_e;

  // One output pin: level and drive enable
  typedef struct packed
  {
    logic d;
    logic oe;
  } ssp_pin_s;

  // Channel 1 setup
  typedef struct packed
  {
    logic chan1_output_on;
    logic [4:0] chan1_slot_index;
  } ssp_ch1_s;

endpackage

// File: ssp_fifo.sv
`timescale 1ns/1ps

module ssp_fifo
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic [AW:0] level;
  logic push;
  logic pop;

  assign level = wr_ptr_r - rd_ptr_r;
  assign in_ready = (level != (AW + 1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr_r[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule

// File: ssp_tx_assertions.sv
`timescale 1ns/1ps
`include "ssp_defs.svh"

module ssp_tx_assertions
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Serial link
  input wire logic bclk_pin,
  input wire ssp_pkg::ssp_pin_s first_serial_out_pin,
  input wire ssp_pkg::ssp_pin_s second_serial_out_pin
);
  logic bclk_d_r;
  logic [3:0] fall_age_r;
  logic aw_go;
  logic ar_go;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  function automatic logic mapped(input logic [5:0] i);
    return i inside {`SSP_IDX_FORMAT, `SSP_IDX_TXCTL, `SSP_IDX_OFFSET, `SSP_IDX_PINSEL, `SSP_IDX_CH1,
      `SSP_IDX_STATUS};
  endfunction

  // ------
  // Cycles since the raw bit clock fell
  // ------
  always_ff @(posedge aclk)
  begin
    bclk_d_r <= bclk_pin;
    if (!aresetn)
      fall_age_r <= 4'hf;
    else if (bclk_d_r && !bclk_pin)
      fall_age_r <= 4'h0;
    else if (fall_age_r != 4'hf)
      fall_age_r <= fall_age_r + 4'h1;
  end

  assign aw_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign ar_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  a_write_answer:
    assert property (aw_go |-> ##1 s_axi_awready && s_axi_wready ##1 s_axi_bvalid) else $error("write answer late");
  a_read_answer:
    assert property (ar_go |-> ##1 s_axi_arready ##1 s_axi_rvalid) else $error("read answer late");
  a_ready_pulse:
    assert property (s_axi_awready |=> !s_axi_awready && !s_axi_wready) else $error("write ready too long");
  a_b_release:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response held");
  a_write_resp:
    assert property (aw_go |-> ##2 s_axi_bresp == (mapped(s_axi_awaddr[7:2]) ? `SSP_RESP_OKAY : `SSP_RESP_DECERR))
      else $error("write response code wrong");
  a_unmapped_read:
    assert property (ar_go && !mapped(s_axi_araddr[7:2]) |-> ##2 s_axi_rresp == `SSP_RESP_DECERR &&
      s_axi_rdata == 32'h0) else $error("unmapped read answer wrong");
  a_offset_rsvd:
    assert property (ar_go && s_axi_araddr[7:2] == `SSP_IDX_OFFSET |-> ##2 s_axi_rdata[31:5] == 27'h0)
      else $error("offset reserved bits set");
  a_idle_level:
    assert property ((first_serial_out_pin.oe || !first_serial_out_pin.d) && (second_serial_out_pin.oe ||
      !second_serial_out_pin.d)) else $error("undriven pin shows one");
  a_one_pin:
    assert property (!(first_serial_out_pin.d && second_serial_out_pin.d)) else $error("both pins carry data");
  a_pins_on_fall:
    assert property ($changed(first_serial_out_pin) || $changed(second_serial_out_pin) |-> fall_age_r <= 4'h6)
      else $error("pin moved without bit clock fall");
endmodule

// File: ssp_host_model.sv
`timescale 1ns/1ps

module ssp_host_model
(
  // Link clock and frame sync
  output logic bclk,
  output logic fsync,
  // Data pins
  input wire ssp_pkg::ssp_pin_s pin_a,
  input wire ssp_pkg::ssp_pin_s pin_b
);
  ssp_pkg::ssp_pin_s cap_a[160];
  ssp_pkg::ssp_pin_s cap_b[160];

  initial
  begin
    bclk = 1'b0;
    fsync = 1'b0;
  end

  function automatic logic lvl(input logic [1:0] f, input int k, input int n);
    if (f == 2'h1)
      return k >= n / 2;
    if (f == 2'h2)
      return k < n / 2;
    return k == 0;
  endfunction

  // ------
  // One frame; bit clock stands low outside it, data taken late in each high phase after the first
  // ------
  task automatic frame(input logic [1:0] f, input int n);
    #7;
    for (int k = -1; k < n; k++)
    begin
      fsync = (k < 0) ? !lvl(f, 0, n) : lvl(f, k, n);
      #80;
      bclk = 1'b1;
      #80;
      if (k >= 0)
      begin
        cap_a[k] = pin_a;
        cap_b[k] = pin_b;
      end
      bclk = 1'b0;
    end
  endtask
endmodule

// File: tb_ssp_tx.sv
`timescale 1ns/1ps
`include "ssp_defs.svh"

module tb_ssp_tx;
  typedef struct packed
  {
    logic [7:0] fmt;
    logic [7:0] ofs;
    logic [7:0] pin;
    logic [7:0] ch1;
    logic [7:0] ctl;
    logic [31:0] smp;
  } ssp_row_s;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, smp_valid, smp_ready;
  logic bclk_pin, fsync_pin;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, smp_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  ssp_pkg::ssp_pin_s first_serial_out_pin, second_serial_out_pin;
  int fail_count, n_checks, s, len;
  ssp_row_s r;
  ssp_row_s rows[7] = '{
    '{8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 32'ha5c3_0000},
    '{8'h10, 8'h1f, 8'h01, 8'h21, 8'h40, 32'h9d2e_1000},
    '{8'h60, 8'h03, 8'h00, 8'h21, 8'h00, 32'hc3a5_5a00},
    '{8'hb0, 8'h05, 8'h01, 8'h30, 8'h40, 32'h8123_4567},
    '{8'h40, 8'h00, 8'h00, 8'h31, 8'h00, 32'hf00f_0000},
    '{8'h00, 8'h00, 8'h01, 8'h00, 8'h40, 32'h0},
    '{8'h30, 8'h00, 8'h00, 8'h23, 8'h00, 32'hdead_beef}
  };

  ssp_tx u_dut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .smp_data(smp_data), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .bclk_pin(bclk_pin), .fsync_pin(fsync_pin),
    .first_serial_out_pin(first_serial_out_pin), .second_serial_out_pin(second_serial_out_pin)
  );
  ssp_host_model u_host (.bclk(bclk_pin), .fsync(fsync_pin), .pin_a(first_serial_out_pin),
    .pin_b(second_serial_out_pin));

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial
  begin
    #1000000;
    fail_count++;
    stop_test();
  end

  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rst();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic axw(input logic [5:0] i, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    cmp({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axr(input logic [5:0] i, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    cmp(s_axi_rdata, ed);
    cmp({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic push(input logic [31:0] d);
    smp_data <= d;
    smp_valid <= 1'b1;
    do @(posedge aclk); while (smp_ready !== 1'b1);
    smp_valid <= 1'b0;
    @(posedge aclk);
  endtask

  // Expected pin for capture index k of the current row
  function automatic ssp_pkg::ssp_pin_s xp(input logic p, input int k);
    int bb;
    bb = k - s - 1;
    if (r.ch1[5] && r.pin[0] == p && bb >= 0 && bb < len)
      return {r.smp[31 - bb], 1'b1};
    return {1'b0, !r.ctl[6]};
  endfunction

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, smp_valid, aresetn} = 5'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, smp_data} = '0;
    s_axi_wstrb = 4'h1;
    fail_count = 0;
    n_checks = 0;
    rst();
    // ------
    // Fill the buffer until it refuses
    // ------
    for (int i = 0; i < 4; i++)
      push(rows[i].smp);
    repeat (2) @(posedge aclk);
    cmp({31'h0, smp_ready}, 32'h0);
    // ------
    // Row table: one frame per row, drains the buffer
    // ------
    foreach (rows[i])
    begin
      r = rows[i];
      if (i >= 4 && r.ch1[5])
        push(r.smp);
      axw(`SSP_IDX_FORMAT, {24'h0, r.fmt}, `SSP_RESP_OKAY);
      axw(`SSP_IDX_OFFSET, {24'h0, r.ofs}, `SSP_RESP_OKAY);
      axw(`SSP_IDX_PINSEL, {24'h0, r.pin}, `SSP_RESP_OKAY);
      axw(`SSP_IDX_CH1, {24'h0, r.ch1}, `SSP_RESP_OKAY);
      axw(`SSP_IDX_TXCTL, {24'h0, r.ctl}, `SSP_RESP_OKAY);
      u_host.frame(r.fmt[7:6], 160);
      len = (r.fmt[5:4] == 2'h3) ? 32 : 16 + 4 * r.fmt[5:4];
      s = r.ofs[4:0] + ((r.fmt[7:6] == 2'h0) ? r.ch1[4:0] * len : r.ch1[3:0] * len + 80 * r.ch1[4]);
      for (int k = 0; k < 160; k++)
      begin
        cmp({30'h0, u_host.cap_a[k]}, {30'h0, xp(1'b0, k)});
        cmp({30'h0, u_host.cap_b[k]}, {30'h0, xp(1'b1, k)});
      end
    end
    cmp({31'h0, smp_ready}, 32'h1);
    // ------
    // Empty buffer at the channel's slot: zeros go out and the sticky flag sets
    // ------
    u_host.frame(2'h0, 160);
    r.smp = 32'h0;
    for (int k = 0; k < 160; k++)
    begin
      cmp({30'h0, u_host.cap_a[k]}, {30'h0, xp(1'b0, k)});
      cmp({30'h0, u_host.cap_b[k]}, {30'h0, xp(1'b1, k)});
    end
    axr(`SSP_IDX_STATUS, 32'h3, `SSP_RESP_OKAY);
    axw(`SSP_IDX_STATUS, 32'h1, `SSP_RESP_OKAY);
    axr(`SSP_IDX_STATUS, 32'h2, `SSP_RESP_OKAY);
    axw(`SSP_IDX_OFFSET, 32'hff, `SSP_RESP_OKAY);
    axr(`SSP_IDX_OFFSET, 32'h1f, `SSP_RESP_OKAY);
    axw(`SSP_IDX_CH1, 32'hff, `SSP_RESP_OKAY);
    axr(`SSP_IDX_CH1, 32'h3f, `SSP_RESP_OKAY);
    axw(6'h3f, 32'h1, `SSP_RESP_DECERR);
    axr(6'h3f, 32'h0, `SSP_RESP_DECERR);
    rst();
    cmp({28'h0, first_serial_out_pin, second_serial_out_pin}, 32'h0);
    axr(`SSP_IDX_FORMAT, 32'h30, `SSP_RESP_OKAY);
    axr(`SSP_IDX_OFFSET, 32'h0, `SSP_RESP_OKAY);
    axr(`SSP_IDX_PINSEL, 32'h0, `SSP_RESP_OKAY);
    axr(`SSP_IDX_CH1, 32'h0, `SSP_RESP_OKAY);
    axr(`SSP_IDX_TXCTL, 32'h0, `SSP_RESP_OKAY);
    stop_test();
  end
endmodule

bind ssp_tx ssp_tx_assertions #(.ADDR_W(ADDR_W)) u_chk
(
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .bclk_pin(bclk_pin),
  .first_serial_out_pin(first_serial_out_pin), .second_serial_out_pin(second_serial_out_pin)
);
